// [verilog/psr_map.svh]
// Register offsets, field positions and reset values for the pulse steering PWM block.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH
`define PSR_OFF_COUNT 8'h00
`define PSR_OFF_TCTRL 8'h04
`define PSR_OFF_LIMIT 8'h08
`define PSR_OFF_DUTYL 8'h0c
`define PSR_OFF_DUTYH 8'h10
`define PSR_OFF_CPCTRL 8'h14
`define PSR_OFF_SDCTRL 8'h18
`define PSR_OFF_RDCTRL 8'h1c
`define PSR_OFF_STEER 8'h20
`define PSR_OFF_PWR 8'h24
`define PSR_OFF_STAT 8'h28
`define PSR_OFF_MASK 8'h2c
`define PSR_RST_STEER 8'h01
`define PSR_STEER_SYNC_BIT 4
`define PSR_TMR_ON_BIT 2
`define PSR_SD_ACTIVE_BIT 7
`define PSR_ST_OSCFAIL 0
`define PSR_ST_PERIOD 1
`define PSR_ST_SHUTDOWN 2
`define PSR_CFG_SINGLE 2'h0
`define PSR_MODE_PWM 2'h3
`define PSR_RESP_OKAY 2'h0
`define PSR_RESP_SLVERR 2'h2
`endif

// [verilog/psr_pkg.sv]
// Types shared by the pulse steering PWM block.
// Assumes the map header supplies offsets and field positions.
package psr_pkg;
	typedef enum logic [1:0] {
		PSR_PM_RUN = 2'h0,
		PSR_PM_PRIMARY_CLOCK_IDLE_MODE = 2'h1,
		PSR_PM_OTHER = 2'h3,
		PSR_PM_SLEEP = 2'h2
	} psr_pwr_type;
	typedef enum logic [1:0] {
		PSR_CK_PRIMARY = 2'h0,
		PSR_CK_PM = 2'h1,
		PSR_CK_INTOSC = 2'h3
	} psr_clksel_type;
endpackage

// [verilog/psr_steer.sv]
// Single-output PWM with four-pin pulse steering, power-managed modes and AXI4-Lite registers.
// Assumes clock ticks from the selected power-mode clock and the internal oscillator arrive
// asynchronously and are synchronised here; pins feed external power switches.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "psr_map.svh"
module psr_steer
#(
	parameter int NPIN = 4
)
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pm_clk_tick,
	input wire logic intosc_tick,
	input wire logic clock_fail,
	input wire logic shutdown_in,
	input wire logic [NPIN-1:0] port_data,
	input wire logic [NPIN-1:0] port_dir_out,
	output logic [NPIN-1:0] pwm_output_pins,
	output logic [NPIN-1:0] pwm_output_pins_oe,
	output psr_pkg::psr_clksel_type clk_source,
	output logic irq
);
	import psr_pkg::*;
	logic [7:0] count_r, count_nxt, tctrl_r, tctrl_nxt, limit_r, limit_nxt;
	logic [7:0] dutyl_r, dutyl_nxt, dutyh_r, dutyh_nxt, cpctrl_r, cpctrl_nxt;
	logic [7:0] sdctrl_r, sdctrl_nxt, rdctrl_r, rdctrl_nxt, steer_r, steer_nxt;
	logic [3:0] steer_act_r, steer_act_nxt;
	logic [1:0] pwr_r, pwr_nxt;
	logic [2:0] stat_r, stat_nxt, mask_r, mask_nxt;
	logic oscfail_r, oscfail_nxt;
	logic [9:0] fine_r, fine_nxt;
	logic [NPIN-1:0] pin_r, pin_nxt, oe_r, oe_nxt;
	logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt;
	logic [7:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic rvalid_r, rvalid_nxt, w_en_r, w_en_nxt;
	logic [3:0] async_in, s1_r, s2_r, s3_r, lvl_r, prev_r;
	psr_pwr_type pwr_mode;
	logic steer_mode, tick, period_start, pwm_raw, wr_fire, wr_hit;
	logic [3:0] pin_pol, sd_mask;
	logic [7:0] wbyte;
	logic [9:0] duty10;
	logic [2:0] ev;

	assign pwr_mode = psr_pwr_type'(pwr_r);
	// Three stage synchronisers; a level changes only when stages two and three agree.
	assign async_in = {shutdown_in, clock_fail, intosc_tick, pm_clk_tick};
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_r <= 4'h0;
			s2_r <= 4'h0;
			s3_r <= 4'h0;
			lvl_r <= 4'h0;
			prev_r <= 4'h0;
		end
		else
		begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= (s3_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));
			prev_r <= lvl_r;
		end
	end

	// Timer source selection; a failed primary clock overrides every mode, sleep included, and sleep stops the tick.
	always_comb
	begin
		if (oscfail_r)
			clk_source = PSR_CK_INTOSC;
		else if (pwr_mode == PSR_PM_OTHER)
			clk_source = PSR_CK_PM;
		else
			clk_source = PSR_CK_PRIMARY;
		case (clk_source)
			PSR_CK_INTOSC: tick = lvl_r[1] & ~prev_r[1];
			PSR_CK_PM: tick = lvl_r[0] & ~prev_r[0];
			default: tick = 1'b1;
		endcase
		if (pwr_mode == PSR_PM_SLEEP)
			tick = 1'b0;
	end

	assign steer_mode = cpctrl_r[7:6] == `PSR_CFG_SINGLE && cpctrl_r[3:2] == `PSR_MODE_PWM;
	assign duty10 = {dutyh_r, cpctrl_r[5:4]};
	assign period_start = tick && tctrl_r[`PSR_TMR_ON_BIT] && count_r == limit_r;
	assign pwm_raw = {count_r, fine_r[1:0]} < duty10;
	assign pin_pol = {2{cpctrl_r[1], cpctrl_r[0]}};
	assign sd_mask = steer_act_r & {4{lvl_r[3] & sdctrl_r[`PSR_SD_ACTIVE_BIT]}};
	assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
	assign wr_hit = wr_fire && w_en_r;
	assign wbyte = wdata_r[7:0];
	assign ev = {lvl_r[3] & steer_mode, period_start, lvl_r[2] & ~oscfail_r};

	always_comb
	begin
		count_nxt = count_r;
		fine_nxt = fine_r;
		tctrl_nxt = tctrl_r;
		limit_nxt = limit_r;
		dutyl_nxt = dutyl_r;
		dutyh_nxt = dutyh_r;
		cpctrl_nxt = cpctrl_r;
		sdctrl_nxt = sdctrl_r;
		rdctrl_nxt = rdctrl_r;
		steer_nxt = steer_r;
		steer_act_nxt = steer_act_r;
		pwr_nxt = pwr_r;
		mask_nxt = mask_r;
		oscfail_nxt = oscfail_r | lvl_r[2];
		stat_nxt = stat_r;
		if (tick && tctrl_r[`PSR_TMR_ON_BIT])
		begin
			fine_nxt = {8'h00, fine_r[1:0] + 2'h1};
			if (fine_r[1:0] == 2'h3)
				count_nxt = period_start ? 8'h00 : count_r + 8'h01;
		end
		if (period_start)
		begin
			dutyh_nxt = dutyl_r;
			if (steer_r[`PSR_STEER_SYNC_BIT])
				steer_act_nxt = steer_r[3:0];
		end
		if (wr_hit)
		begin
			case (awaddr_r)
				`PSR_OFF_COUNT: count_nxt = wbyte;
				`PSR_OFF_TCTRL: tctrl_nxt = {1'b0, wbyte[6:0]};
				`PSR_OFF_LIMIT: limit_nxt = wbyte;
				`PSR_OFF_DUTYL: dutyl_nxt = wbyte;
				`PSR_OFF_CPCTRL: cpctrl_nxt = wbyte;
				`PSR_OFF_SDCTRL: sdctrl_nxt = wbyte;
				`PSR_OFF_RDCTRL: rdctrl_nxt = wbyte;
				`PSR_OFF_STEER:
				begin
					steer_nxt = {3'h0, wbyte[4:0]};
					if (!wbyte[`PSR_STEER_SYNC_BIT])
						steer_act_nxt = wbyte[3:0];
				end
				`PSR_OFF_PWR: pwr_nxt = wbyte[1:0];
				`PSR_OFF_MASK: mask_nxt = wbyte[2:0];
				`PSR_OFF_STAT: stat_nxt = stat_r & ~wbyte[2:0];
				default: ;
			endcase
		end
		stat_nxt = stat_nxt | ev;
		// Sleep freezes the timer, the duty latch and the active steering, writes to COUNT included; other register writes and status still update.
		if (pwr_mode == PSR_PM_SLEEP && !(wr_hit && awaddr_r == `PSR_OFF_PWR))
		begin
			count_nxt = count_r;
			fine_nxt = fine_r;
			steer_act_nxt = steer_act_r;
			dutyh_nxt = dutyh_r;
		end
	end

	// Pin drive; in sleep the last level is held because pin_r is not reloaded.
	always_comb
	begin
		pin_nxt = pin_r;
		oe_nxt = oe_r;
		if (pwr_mode != PSR_PM_SLEEP)
		begin
			oe_nxt = port_dir_out;
			for (int i = 0; i < NPIN; i++)
			begin
				if (steer_mode && steer_act_r[i])
					pin_nxt[i] = sd_mask[i] ? 1'b0 : (pwm_raw ^ pin_pol[i]);
				else
					pin_nxt[i] = port_data[i];
			end
		end
	end

	always_comb
	begin
		aw_got_nxt = aw_got_r | (s_axi_awvalid & ~aw_got_r);
		w_got_nxt = w_got_r | (s_axi_wvalid & ~w_got_r);
		awaddr_nxt = (s_axi_awvalid && !aw_got_r) ? s_axi_awaddr[7:0] : awaddr_r;
		wdata_nxt = (s_axi_wvalid && !w_got_r) ? s_axi_wdata : wdata_r;
		w_en_nxt = (s_axi_wvalid && !w_got_r) ? s_axi_wstrb[0] : w_en_r;
		bvalid_nxt = bvalid_r & ~s_axi_bready;
		bresp_nxt = bresp_r;
		if (wr_fire)
		begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = awaddr_r > `PSR_OFF_MASK || awaddr_r[1:0] != 2'h0 ?
				`PSR_RESP_SLVERR : `PSR_RESP_OKAY;
		end
		rvalid_nxt = rvalid_r & ~s_axi_rready;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid && !rvalid_r)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt = `PSR_RESP_OKAY;
			case (s_axi_araddr[7:0])
				`PSR_OFF_COUNT: rdata_nxt = {24'h0, count_r};
				`PSR_OFF_TCTRL: rdata_nxt = {24'h0, tctrl_r};
				`PSR_OFF_LIMIT: rdata_nxt = {24'h0, limit_r};
				`PSR_OFF_DUTYL: rdata_nxt = {24'h0, dutyl_r};
				`PSR_OFF_DUTYH: rdata_nxt = {24'h0, dutyh_r};
				`PSR_OFF_CPCTRL: rdata_nxt = {24'h0, cpctrl_r};
				`PSR_OFF_SDCTRL: rdata_nxt = {24'h0, sdctrl_r};
				`PSR_OFF_RDCTRL: rdata_nxt = {24'h0, rdctrl_r};
				`PSR_OFF_STEER: rdata_nxt = {24'h0, steer_r};
				`PSR_OFF_PWR: rdata_nxt = {28'h0, clk_source, pwr_r};
				`PSR_OFF_STAT: rdata_nxt = {29'h0, stat_r};
				`PSR_OFF_MASK: rdata_nxt = {29'h0, mask_r};
				default:
				begin
					rdata_nxt = 32'h0;
					rresp_nxt = `PSR_RESP_SLVERR;
				end
			endcase
		end
	end
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			count_r <= 8'h00;
			fine_r <= 10'h000;
			tctrl_r <= 8'h00;
			limit_r <= 8'hff;
			dutyl_r <= 8'h00;
			dutyh_r <= 8'h00;
			cpctrl_r <= 8'h00;
			sdctrl_r <= 8'h00;
			rdctrl_r <= 8'h00;
			steer_r <= `PSR_RST_STEER;
			steer_act_r <= 4'h1;
			pwr_r <= 2'h0;
			stat_r <= 3'h0;
			mask_r <= 3'h0;
			oscfail_r <= 1'b0;
			pin_r <= '0;
			oe_r <= '0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			bvalid_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0;
			w_en_r <= 1'b0;
			bresp_r <= 2'h0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= 2'h0;
		end
		else
		begin
			count_r <= count_nxt;
			fine_r <= fine_nxt;
			tctrl_r <= tctrl_nxt;
			limit_r <= limit_nxt;
			dutyl_r <= dutyl_nxt;
			dutyh_r <= dutyh_nxt;
			cpctrl_r <= cpctrl_nxt;
			sdctrl_r <= sdctrl_nxt;
			rdctrl_r <= rdctrl_nxt;
			steer_r <= steer_nxt;
			steer_act_r <= steer_act_nxt;
			pwr_r <= pwr_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			oscfail_r <= oscfail_nxt;
			pin_r <= pin_nxt;
			oe_r <= oe_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			bvalid_r <= bvalid_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			w_en_r <= w_en_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end
	assign s_axi_awready = !aw_got_r;
	assign s_axi_wready = !w_got_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign pwm_output_pins = pin_r;
	assign pwm_output_pins_oe = oe_r;
	assign irq = |(stat_r & mask_r);
	immediate_steer_a: assert property (@(posedge core_clk) disable iff (!rstn)
		wr_hit && awaddr_r == `PSR_OFF_STEER && !wbyte[4] && pwr_mode != PSR_PM_SLEEP
		|=> steer_act_r == $past(wbyte[3:0]))
		else $error("Immediate steering not applied.");
	sync_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!period_start && !(wr_hit && awaddr_r == `PSR_OFF_STEER)
		|=> $stable(steer_act_r))
		else $error("Steering changed outside a period start.");
	sleep_freeze_a: assert property (@(posedge core_clk) disable iff (!rstn)
		pwr_mode == PSR_PM_SLEEP && !wr_hit |=> $stable(count_r) && $stable(fine_r))
		else $error("Timer moved in sleep.");
	sleep_pins_a: assert property (@(posedge core_clk) disable iff (!rstn)
		pwr_mode == PSR_PM_SLEEP |=> $stable(pwm_output_pins))
		else $error("Pins changed in sleep.");
	fail_switch_a: assert property (@(posedge core_clk) disable iff (!rstn)
		lvl_r[2] |=> oscfail_r && clk_source == PSR_CK_INTOSC && (stat_r[0] || $past(oscfail_r)))
		else $error("Clock failure not handled.");
	pm_source_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!oscfail_r && pwr_mode == PSR_PM_OTHER |-> clk_source == PSR_CK_PM)
		else $error("Wrong clock in power mode.");
	port_release_a: assert property (@(posedge core_clk) disable iff (!rstn)
		pwr_mode != PSR_PM_SLEEP && !(steer_mode && steer_act_r[0])
		|=> pwm_output_pins[0] == $past(port_data[0]))
		else $error("Pin not returned to port.");
	shutdown_pin_a: assert property (@(posedge core_clk) disable iff (!rstn)
		pwr_mode != PSR_PM_SLEEP && steer_mode && sd_mask[0] |=> !pwm_output_pins[0])
		else $error("Shutdown missed steered pin.");
	period_wrap_a: assert property (@(posedge core_clk) disable iff (!rstn)
		period_start && fine_r[1:0] == 2'h3 && pwr_mode != PSR_PM_SLEEP && !wr_hit
		|=> count_r == 8'h00)
		else $error("Timer did not restart at limit.");
	steer_on_c: cover property (@(posedge core_clk) steer_mode && steer_act_r == 4'hf);
	sync_upd_c: cover property (@(posedge core_clk) period_start && steer_r[4]);
	sleep_c: cover property (@(posedge core_clk) pwr_mode == PSR_PM_SLEEP);
	fail_c: cover property (@(posedge core_clk) irq && stat_r[0]);
endmodule

// [verif/psr_load.sv]
// Load model for the block's far side: power switch gates on the steered pins.
// Assumes the block drives a pin level and a drive enable for each pin.
`timescale 1ns/100ps
module psr_load
#(
	parameter int NPIN = 4
)
(
	input wire logic [NPIN-1:0] pin,
	input wire logic [NPIN-1:0] oe,
	output logic [NPIN-1:0] level
);
	// Each gate has a pull-down, so an undriven pin reads low and its switch stays off.
	assign level = pin & oe;
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the pulse steering block, with the load model on its pins.
// Assumes the register map header and a 100 MHz core clock; bus answers are queued.
`timescale 1ns/100ps
`include "psr_map.svh"
module tb_top;
	import psr_pkg::*;
	logic core_clk = 0;
	logic rstn = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic pm_tick = 0, osc_tick = 0, clock_fail = 0, shutdown_in = 0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [3:0] port_data = 4'hf, wstrb = 4'hf, port_dir = 4'hf, pins, oe, level, snap;
	psr_clksel_type clk_source;
	int n_mismatch = 0, cmp_count = 0, cyc = 0;
	logic [33:0] expq[$];
	psr_steer psr_steer_inst (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pm_clk_tick(pm_tick), .intosc_tick(osc_tick),
		.clock_fail(clock_fail), .shutdown_in(shutdown_in), .port_data(port_data),
		.port_dir_out(port_dir), .pwm_output_pins(pins), .pwm_output_pins_oe(oe),
		.clk_source(clk_source), .irq(irq));
	psr_load psr_load_inst (.pin(pins), .oe(oe), .level(level));
	initial
	begin
		forever #5 core_clk = ~core_clk;
	end
	task chk(input logic [33:0] seen, input logic [33:0] exp, input string m);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// The power-mode and oscillator ticks run slower than the core clock, as they would.
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		pm_tick <= cyc[1];
		osc_tick <= ~cyc[2];
		if (cyc == 30000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end
	// Bus answers are taken at the falling edge, where they have settled.
	always @(negedge core_clk)
	begin
		if (bvalid && bready)
			chk({bresp, 32'h0}, expq.pop_front(), "write response");
		if (rvalid && rready)
			chk({rresp, rdata}, expq.pop_front(), "read data");
	end
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		logic ah, wh, bh;
		expq.push_back({r, 32'h0});
		@(posedge core_clk);
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(negedge core_clk);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid;
			@(posedge core_clk);
			if (ah)
				awvalid <= 1'b0;
			if (wh)
				wvalid <= 1'b0;
			if (bh)
			begin
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
		logic ah, rh;
		expq.push_back({r, e});
		@(posedge core_clk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(negedge core_clk);
			ah = arvalid & arready;
			rh = rvalid;
			@(posedge core_clk);
			if (ah)
				arvalid <= 1'b0;
			if (rh)
			begin
				rready <= 1'b0;
				break;
			end
		end
	endtask
	task settle(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	initial
	begin
		void'($urandom(32'hc38717da));
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		rd(`PSR_OFF_STEER, 32'h1);
		rd(`PSR_OFF_LIMIT, 32'hff);
		rd(`PSR_OFF_CPCTRL, 32'h0);
		rd(8'h40, 32'h0, 2'h2);
		wr(8'h44, 32'h5, 2'h2);
		wstrb <= 4'h0;
		wr(`PSR_OFF_LIMIT, 32'h3);
		wstrb <= 4'hf;
		rd(`PSR_OFF_LIMIT, 32'hff);
		$display("test reset and map done");
		wr(`PSR_OFF_LIMIT, 32'h3);
		wr(`PSR_OFF_DUTYL, 32'h0);
		wr(`PSR_OFF_CPCTRL, 32'h0c);
		wr(`PSR_OFF_STEER, 32'h0f);
		settle(3);
		chk(level, 4'h0, "all pins steered");
		// Timer still off, so no period can start while the held setting waits.
		wr(`PSR_OFF_STEER, 32'h11);
		settle(20);
		chk(level, 4'h0, "held steering");
		wr(`PSR_OFF_TCTRL, 32'h4);
		for (int i = 0; i < 300 && level !== 4'he; i++) @(negedge core_clk);
		chk(level, 4'he, "steering at period start");
		wr(`PSR_OFF_STEER, 32'h00);
		settle(2);
		chk(level, 4'hf, "immediate steering off");
		$display("test steering sync done");
		wr(`PSR_OFF_DUTYL, 32'hff);
		wr(`PSR_OFF_STEER, 32'h05);
		settle(60);
		for (int p = 0; p < 4; p++)
		begin
			wr(`PSR_OFF_CPCTRL, 32'h0c | p);
			port_data <= 4'($urandom);
			settle(3);
			chk(level & 4'ha, port_data & 4'ha, "port pins");
			chk(level[0], level[2], "shared polarity");
			if (p == 0)
				chk(level[0], 1'b1, "full duty");
		end
		wr(`PSR_OFF_CPCTRL, 32'h0c);
		port_dir <= 4'h6;
		settle(3);
		chk(oe, 4'h6, "drive follows direction");
		chk(level & 4'h9, 4'h0, "undriven pins low");
		@(posedge core_clk);
		port_dir <= 4'hf;
		$display("test routing and polarity done");
		wr(`PSR_OFF_TCTRL, 32'h0);
		wr(`PSR_OFF_STAT, 32'h7);
		wr(`PSR_OFF_MASK, 32'h2);
		settle(2);
		chk(irq, 1'b0, "irq cleared");
		wr(`PSR_OFF_TCTRL, 32'h4);
		for (int i = 0; i < 300 && irq !== 1'b1; i++) @(negedge core_clk);
		chk(irq, 1'b1, "period irq");
		wr(`PSR_OFF_TCTRL, 32'h0);
		wr(`PSR_OFF_STAT, 32'h2);
		settle(2);
		chk(irq, 1'b0, "irq after clear");
		wr(`PSR_OFF_MASK, 32'h0);
		wr(`PSR_OFF_TCTRL, 32'h4);
		settle(100);
		chk(irq, 1'b0, "masked irq");
		rd(`PSR_OFF_STAT, 32'h2);
		$display("test interrupt done");
		port_data <= 4'hf;
		wr(`PSR_OFF_SDCTRL, 32'h80);
		settle(3);
		chk(level, 4'hf, "no shutdown without event");
		@(posedge core_clk);
		shutdown_in <= 1'b1;
		settle(8);
		chk(level, 4'ha, "shutdown of steered pins only");
		@(posedge core_clk);
		shutdown_in <= 1'b0;
		wr(`PSR_OFF_SDCTRL, 32'h0);
		$display("test shutdown done");
		wr(`PSR_OFF_PWR, 32'h1);
		settle(2);
		chk(clk_source, PSR_CK_PRIMARY, "primary idle clock");
		wr(`PSR_OFF_PWR, 32'h3);
		settle(2);
		chk(clk_source, PSR_CK_PM, "power mode clock");
		rd(`PSR_OFF_PWR, 32'h7);
		wr(`PSR_OFF_PWR, 32'h0);
		wr(`PSR_OFF_DUTYL, 32'h2);
		wr(`PSR_OFF_STEER, 32'h01);
		settle(60);
		wr(`PSR_OFF_PWR, 32'h2);
		settle(2);
		snap = level;
		for (int i = 0; i < 40; i++)
		begin
			chk(level, snap, "pins frozen in sleep");
			@(negedge core_clk);
		end
		wr(`PSR_OFF_PWR, 32'h0);
		for (int i = 0; i < 300 && level === snap; i++) @(negedge core_clk);
		chk(level !== snap, 1'b1, "resume after wake");
		$display("test power modes done");
		wr(`PSR_OFF_TCTRL, 32'h0);
		wr(`PSR_OFF_STAT, 32'h7);
		clock_fail <= 1'b1;
		settle(8);
		chk(clk_source, PSR_CK_INTOSC, "internal oscillator");
		rd(`PSR_OFF_STAT, 32'h1);
		wr(`PSR_OFF_MASK, 32'h1);
		settle(2);
		chk(irq, 1'b1, "oscillator fail irq");
		$display("test clock failure done");
		@(posedge core_clk);
		clock_fail <= 1'b0;
		rstn <= 1'b0;
		settle(2);
		chk(oe, 4'h0, "pins input in reset");
		chk(irq, 1'b0, "irq in reset");
		@(posedge core_clk);
		rstn <= 1'b1;
		rd(`PSR_OFF_STEER, 32'h1);
		rd(`PSR_OFF_PWR, 32'h0);
		rd(`PSR_OFF_MASK, 32'h0);
		$display("test second reset done");
		report_and_stop();
	end
endmodule
